// *** core/buck_supervisory_control_defs.vh ***
// Constants for the buck supervisory control block.
// Assumes a 100 MHz core clock and AHB-Lite word registers.
`ifndef BUCK_SUPERVISORY_CONTROL_DEFS_VH
`define BUCK_SUPERVISORY_CONTROL_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RAMP 8'h08
`define REG_ZC_COUNT 8'h0c

// Control register fields and reset value
`define CTRL_FF_ALLOW 0
`define CTRL_BRAKE_ALLOW 1
`define CTRL_RESET 32'h0000_0003

// Status register fields
`define ST_OV_LATCH 0
`define ST_PG 1
`define ST_GATE_LOW 2
`define ST_BRAKING 3
`define ST_FF_ACTIVE 4
`define ST_OV_TRIP 5

// Feed-forward: input code in 0.1 V steps, ramp code in 0.01 V steps
`define POWER_INPUT_VOLTAGE_FF_MIN 8'h3e
`define RAMP_FIXED 9'h05a

// Zero-crossing cycles before the low gate-drive level
`define ZC_TERMINAL 9'h100

// Over-voltage trip delay
`define CLK_PERIOD_NS 10
`define OV_DELAY_NS 2500
`define OV_DELAY_CYCLES (`OV_DELAY_NS / `CLK_PERIOD_NS)

// AHB transfer type
`define HTRANS_NONSEQ 2'b10

`endif

// *** core/pin_sync.v ***
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the levels change slowly compared with CLK.
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire CLK,
    input wire RST,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge CLK)
    begin
        if (RST)
        begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // pin_sync

// *** core/buck_supervisory_control.v ***
// Supervisory and mode control of a synchronous buck regulator.
// Assumes comparator levels arrive asynchronously on pins, POWER_INPUT_VOLTAGE_CODE comes
// from an on-chip converter clocked by CLK, and RST follows supply cycling.
// Functional notes
// - Feed-forward ramp is 0.15 of input voltage
// - Below 6.2 V: no feed-forward, ramp 0.9 V
// - 256 zero-crossing cycles select low gate drive
// - Zero crossing sampled at low-side drive fall
// - Missing zero crossing clears count, high drive
// - Each turn-on starts at high gate drive
// - Enable low selects low gate drive
// - Power good inside over-voltage and lower window
// - Lower bound has assert and release thresholds
// - Power good low while enable low
// - Power good only pulls low, external pull-up
// - Over-voltage trip after 2.5 us delay
// - Trip latches high side off, power good low
// - Low side on while sense above threshold
// - Latch cleared only by supply cycling
// - Over-voltage logic works regardless of enable
// - First skipped pulse starts braking, low side off
// - No braking during pre-bias startup
// - Over-voltage latch overrides braking, low side on
// - Enable low turns both drivers off
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "buck_supervisory_control_defs.vh"
module buck_supervisory_control #(
    parameter OV_DELAY = `OV_DELAY_CYCLES
) (
    input wire CLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire ENABLE,
    input wire PWM_DEMAND,
    input wire CYCLE_START,
    input wire ZERO_CROSS,
    input wire VSNS_OV,
    input wire VSNS_PG_ASSERT,
    input wire VSNS_PG_RELEASE,
    input wire PREBIAS,
    input wire [7:0] POWER_INPUT_VOLTAGE_CODE,
    output reg HIGH_SIDE_DRIVE,
    output reg LOW_SIDE_DRIVE,
    output reg POWER_GOOD_OUTPUT,
    output reg POWER_GOOD_OE,
    output reg GATE_DRIVE_LOW,
    output reg FEED_FORWARD_ON,
    output reg [8:0] RAMP_CODE,
    output reg OVERVOLTAGE_TRIP
);
    wire [7:0] pins;
    wire en;
    wire pwm;
    wire cyc;
    wire zc;
    wire ov;
    wire pg_hi;
    wire pg_lo;
    wire prebias;
    reg en_d;
    reg cyc_d;
    reg pulse_seen;
    reg ov_latch;
    reg [8:0] ov_cnt;
    reg [8:0] zc_cnt;
    reg pg;
    reg braking;
    reg [31:0] ctrl;
    reg [7:0] addr_q;
    reg wr_q;
    reg next_hs;
    reg next_ls;
    wire ff_ok;
    wire cyc_rise;
    wire ls_fall;

    function [8:0] ramp_of;
        input [7:0] code;
        begin
            ramp_of = {1'b0, code} + {2'b00, code[7:1]};
        end
    endfunction

    function valid_access;
        input sel;
        input rdy;
        input [1:0] trans;
        input [2:0] size;
        begin
            valid_access = sel & rdy & trans[1] & (size == 3'b010);
        end
    endfunction

    pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .d({PREBIAS, VSNS_PG_RELEASE, VSNS_PG_ASSERT, VSNS_OV, ZERO_CROSS, CYCLE_START, PWM_DEMAND, ENABLE}),
        .q(pins)
    );

    assign en = pins[0];
    assign pwm = pins[1];
    assign cyc = pins[2];
    assign zc = pins[3];
    assign ov = pins[4];
    assign pg_hi = pins[5];
    assign pg_lo = pins[6];
    assign prebias = pins[7];
    assign cyc_rise = cyc & ~cyc_d;
    assign ls_fall = LOW_SIDE_DRIVE & ~next_ls;
    assign ff_ok = ctrl[`CTRL_FF_ALLOW] & (POWER_INPUT_VOLTAGE_CODE >= `POWER_INPUT_VOLTAGE_FF_MIN);

    // Edge history
    always @(posedge CLK)
    begin
        if (RST)
        begin
            en_d <= 1'b0;
            cyc_d <= 1'b0;
        end
        else
        begin
            en_d <= en;
            cyc_d <= cyc;
        end
    end

    // Feed-forward ramp selection
    always @(posedge CLK)
    begin
        if (RST)
        begin
            FEED_FORWARD_ON <= 1'b0;
            RAMP_CODE <= `RAMP_FIXED;
        end
        else if (ff_ok)
        begin
            FEED_FORWARD_ON <= 1'b1;
            RAMP_CODE <= ramp_of(POWER_INPUT_VOLTAGE_CODE);
        end
        else
        begin
            FEED_FORWARD_ON <= 1'b0;
            RAMP_CODE <= `RAMP_FIXED;
        end
    end

    // Over-voltage delay and latch, independent of enable
    always @(posedge CLK)
    begin
        if (RST)
        begin
            ov_cnt <= 9'h000;
            ov_latch <= 1'b0;
            OVERVOLTAGE_TRIP <= 1'b0;
        end
        else
        begin
            if (!ov)
                ov_cnt <= 9'h000;
            else if (ov_cnt != OV_DELAY[8:0])
                ov_cnt <= ov_cnt + 9'h001;
            OVERVOLTAGE_TRIP <= ov & (ov_cnt == OV_DELAY[8:0]);
            if (ov & (ov_cnt == OV_DELAY[8:0]))
                ov_latch <= 1'b1;
        end
    end

    // Skipped pulse detection and braking
    always @(posedge CLK)
    begin
        if (RST)
        begin
            pulse_seen <= 1'b0;
            braking <= 1'b0;
        end
        else
        begin
            if (cyc_rise)
                pulse_seen <= pwm;
            else if (pwm)
                pulse_seen <= 1'b1;
            if (!en | prebias | ~ctrl[`CTRL_BRAKE_ALLOW])
                braking <= 1'b0;
            else if (pwm)
                braking <= 1'b0;
            else if (cyc_rise & ~pulse_seen)
                braking <= 1'b1;
        end
    end

    // Driver decision
    always @*
    begin
        next_hs = 1'b0;
        next_ls = 1'b0;
        if (ov_latch & ov)
            next_ls = 1'b1;
        else if (ov_latch)
            next_ls = 1'b0;
        else if (!en)
            next_ls = 1'b0;
        else if (braking)
            next_ls = 1'b0;
        else
        begin
            next_hs = pwm;
            next_ls = ~pwm;
        end
    end

    always @(posedge CLK)
    begin
        if (RST)
        begin
            HIGH_SIDE_DRIVE <= 1'b0;
            LOW_SIDE_DRIVE <= 1'b0;
        end
        else
        begin
            HIGH_SIDE_DRIVE <= next_hs;
            LOW_SIDE_DRIVE <= next_ls;
        end
    end

    // Gate-drive regulator level
    always @(posedge CLK)
    begin
        if (RST)
        begin
            zc_cnt <= 9'h000;
            GATE_DRIVE_LOW <= 1'b1;
        end
        else if (!en)
        begin
            zc_cnt <= 9'h000;
            GATE_DRIVE_LOW <= 1'b1;
        end
        else if (!en_d)
        begin
            zc_cnt <= 9'h000;
            GATE_DRIVE_LOW <= 1'b0;
        end
        else if (ls_fall)
        begin
            if (zc)
            begin
                if (zc_cnt != `ZC_TERMINAL)
                    zc_cnt <= zc_cnt + 9'h001;
                if (zc_cnt + 9'h001 >= `ZC_TERMINAL)
                    GATE_DRIVE_LOW <= 1'b1;
            end
            else
            begin
                zc_cnt <= 9'h000;
                GATE_DRIVE_LOW <= 1'b0;
            end
        end
    end

    // Power-good window with lower hysteresis
    always @(posedge CLK)
    begin
        if (RST)
        begin
            pg <= 1'b0;
            POWER_GOOD_OUTPUT <= 1'b0;
            POWER_GOOD_OE <= 1'b1;
        end
        else
        begin
            if (!en | ov_latch | ov)
                pg <= 1'b0;
            else if (!pg)
                pg <= pg_hi;
            else
                pg <= pg_lo;
            POWER_GOOD_OUTPUT <= 1'b0;
            POWER_GOOD_OE <= ~pg;
        end
    end

    // AHB-Lite slave, zero wait states
    always @(posedge CLK)
    begin
        if (RST)
        begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            ctrl <= `CTRL_RESET;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            if (wr_q & (addr_q == `REG_CTRL))
                ctrl <= {30'h0, HWDATA[1:0]};
            wr_q <= 1'b0;
            if (valid_access(HSEL, HREADY, HTRANS, HSIZE))
            begin
                addr_q <= HADDR[7:0];
                wr_q <= HWRITE;
                case (HADDR[7:0])
                    `REG_CTRL: HRDATA <= ctrl;
                    `REG_STATUS: HRDATA <= {26'h0, OVERVOLTAGE_TRIP, FEED_FORWARD_ON, braking,
                        GATE_DRIVE_LOW, pg, ov_latch};
                    `REG_RAMP: HRDATA <= {23'h0, RAMP_CODE};
                    `REG_ZC_COUNT: HRDATA <= {23'h0, zc_cnt};
                    default: HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // buck_supervisory_control

// *** testbench/buck_far_side.sv ***
// Far-side model: switching cycle source, modulator demand and power-good pull-up.
// Assumes the core clock CLK; the switching period is 16 clocks.
`timescale 1ns/1ps
module buck_far_side (
    input wire CLK,
    input wire skip,
    input wire POWER_GOOD_OUTPUT,
    input wire POWER_GOOD_OE,
    output reg CYCLE_START = 1'b0,
    output reg PWM_DEMAND = 1'b0,
    output wire pg_pin
);
    reg [3:0] phase = 4'h0;
    always @(posedge CLK)
    begin
        phase <= phase + 4'h1;
        CYCLE_START <= phase < 4'h8;
        PWM_DEMAND <= !skip && phase < 4'h4;
    end
    // External pull-up makes the high level
    assign pg_pin = POWER_GOOD_OE ? POWER_GOOD_OUTPUT : 1'b1;
endmodule // buck_far_side

// *** testbench/buck_supervisory_control_props.sv ***
// Port checks for the buck supervisory control block.
// Assumes one clock CLK with synchronous active-high RST.
`timescale 1ns/1ps
`include "buck_supervisory_control_defs.vh"
module buck_supervisory_control_props #(
    parameter OV_DELAY = 250
) (
    input wire CLK,
    input wire RST,
    input wire ENABLE,
    input wire VSNS_OV,
    input wire VSNS_PG_RELEASE,
    input wire HIGH_SIDE_DRIVE,
    input wire LOW_SIDE_DRIVE,
    input wire POWER_GOOD_OUTPUT,
    input wire POWER_GOOD_OE,
    input wire GATE_DRIVE_LOW,
    input wire FEED_FORWARD_ON,
    input wire [8:0] RAMP_CODE,
    input wire OVERVOLTAGE_TRIP
);
    reg tripped;
    reg [9:0] ov_run;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    always @(posedge CLK)
    begin
        tripped <= !RST && (tripped || OVERVOLTAGE_TRIP);
        ov_run <= (RST || !VSNS_OV) ? 10'h000 : ov_run + {9'h000, ov_run != 10'h3ff};
    end
    a_trip_drive_off: assert property (tripped |-> !HIGH_SIDE_DRIVE)
        else $error("high side on after trip");
    a_trip_delay: assert property ($rose(OVERVOLTAGE_TRIP) |-> ov_run >= OV_DELAY && ov_run <= OV_DELAY + 6)
        else $error("trip delay wrong");
    a_trip_pg_low: assert property (OVERVOLTAGE_TRIP |-> ##1 POWER_GOOD_OE)
        else $error("power good not low on trip");
    a_trip_low_on: assert property (OVERVOLTAGE_TRIP && ENABLE && $past(ENABLE, 8) |->
        ##1 (LOW_SIDE_DRIVE || !OVERVOLTAGE_TRIP))
        else $error("low side off during trip");
    a_pg_enable_low: assert property (!ENABLE [*5] |-> POWER_GOOD_OE)
        else $error("power good with enable low");
    a_pg_below_window: assert property (!VSNS_PG_RELEASE [*5] |-> POWER_GOOD_OE)
        else $error("power good below window");
    a_pg_pulldown_only: assert property (!POWER_GOOD_OUTPUT)
        else $error("power good driven high");
    a_ramp_fixed_level: assert property (!FEED_FORWARD_ON && !$past(FEED_FORWARD_ON) |-> RAMP_CODE == `RAMP_FIXED)
        else $error("ramp not fixed level");
    a_gate_enable_low: assert property (!ENABLE [*4] |-> GATE_DRIVE_LOW)
        else $error("gate drive high with enable low");
    a_drive_enable_low: assert property (!ENABLE [*4] |-> !HIGH_SIDE_DRIVE)
        else $error("high side on with enable low");
endmodule // buck_supervisory_control_props
bind buck_supervisory_control buck_supervisory_control_props #(.OV_DELAY(OV_DELAY)) props (.*);

// *** testbench/testbench.sv ***
// Self-checking bench for the buck supervisory control block.
// Assumes the far-side model supplies cycles and the power-good pull-up.
`timescale 1ns/1ps
`include "buck_supervisory_control_defs.vh"
`define CHK(n, e, v) tests_run++; if ((v) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, v); end
module testbench;
    localparam OVD = 5;
    reg CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, ENABLE = 0, ZERO_CROSS = 0, VSNS_OV = 0, PREBIAS = 0;
    reg VSNS_PG_ASSERT = 0, VSNS_PG_RELEASE = 0, skip = 0, seen_hs, seen_ls;
    reg [31:0] HADDR = 0, HWDATA = 0, rd;
    reg [1:0] HTRANS = 0;
    reg [2:0] HSIZE = 3'h2;
    reg [7:0] POWER_INPUT_VOLTAGE_CODE = 8'h00, c;
    reg [7:0] codes [0:3] = '{8'h3d, 8'h3e, 8'h78, 8'hff};
    integer failures = 0, tests_run = 0, i;
    wire [31:0] HRDATA;
    wire [8:0] RAMP_CODE;
    wire HREADYOUT, HRESP, HIGH_SIDE_DRIVE, LOW_SIDE_DRIVE, POWER_GOOD_OUTPUT, POWER_GOOD_OE;
    wire GATE_DRIVE_LOW, FEED_FORWARD_ON, OVERVOLTAGE_TRIP, CYCLE_START, PWM_DEMAND, pg_pin;
    buck_supervisory_control #(.OV_DELAY(OVD)) dut (.HREADY(HREADYOUT), .*);
    buck_far_side partner (.*);
    always #5 CLK = ~CLK;
    task w(input integer n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task ahb(input w_en, input [31:0] a, input [31:0] d);
        begin
            @(posedge CLK);
            {HSEL, HWRITE, HADDR, HTRANS, HSIZE} <= {1'b1, w_en, a, `HTRANS_NONSEQ, 3'h2};
            do @(posedge CLK); while (HREADYOUT !== 1'b1);
            {HSEL, HTRANS, HWDATA} <= {1'b0, 2'b00, d};
            do @(posedge CLK); while (HREADYOUT !== 1'b1);
            rd = HRDATA;
        end
    endtask
    task watch(input integer n);
        begin
            {seen_hs, seen_ls} = 2'b00;
            repeat (n)
            begin
                w(1);
                seen_hs |= HIGH_SIDE_DRIVE;
                seen_ls |= LOW_SIDE_DRIVE;
            end
        end
    endtask
    task lfall;
        @(negedge LOW_SIDE_DRIVE);
        w(1);
    endtask
    task do_reset;
        RST <= 1;
        w(8);
        RST <= 0;
    endtask
    task wait_trip(output integer n);
        for (n = 0; OVERVOLTAGE_TRIP !== 1'b1; n++) w(1);
    endtask
    task t_bus;
        begin
            ahb(0, `REG_CTRL, 0);
            `CHK("ctrl", `CTRL_RESET, rd)
            `CHK("hresp", 1'b0, HRESP)
            ahb(1, `REG_CTRL, 32'hffff_fffd);
            ahb(0, `REG_CTRL, 0);
            `CHK("ctrl write", 32'h0000_0001, rd)
            ahb(1, `REG_CTRL, `CTRL_RESET);
            ahb(0, `REG_CTRL, 0);
            `CHK("ctrl restore", `CTRL_RESET, rd)
            ahb(1, 32'h10, 32'hffff_ffff);
            ahb(0, 32'h10, 0);
            `CHK("unmapped", 32'h0, rd)
        end
    endtask
    task t_ff;
        for (i = 0; i < 4; i++)
        begin
            c = codes[i];
            POWER_INPUT_VOLTAGE_CODE <= c;
            w(4);
            `CHK("ff on", c >= `POWER_INPUT_VOLTAGE_FF_MIN, FEED_FORWARD_ON)
            `CHK("ramp", c >= `POWER_INPUT_VOLTAGE_FF_MIN ? {1'b0, c} + c[7:1] : `RAMP_FIXED, RAMP_CODE)
        end
    endtask
    task t_gate;
        begin
            ENABLE <= 0;
            w(6);
            `CHK("gate idle", 1'b1, GATE_DRIVE_LOW)
            ENABLE <= 1;
            w(6);
            `CHK("gate start", 1'b0, GATE_DRIVE_LOW)
            lfall;
            ZERO_CROSS <= 1;
            for (i = 0; i < 255; i++) lfall;
            w(4);
            `CHK("gate 255", 1'b0, GATE_DRIVE_LOW)
            lfall;
            w(4);
            `CHK("gate 256", 1'b1, GATE_DRIVE_LOW)
            lfall;
            lfall;
            `CHK("gate sat", 1'b1, GATE_DRIVE_LOW)
            ZERO_CROSS <= 0;
            lfall;
            w(4);
            `CHK("gate miss", 1'b0, GATE_DRIVE_LOW)
        end
    endtask
    task t_brake;
        begin
            skip <= 1;
            @(posedge CYCLE_START);
            @(posedge CYCLE_START);
            w(6);
            watch(20);
            `CHK("brake ls", 1'b0, seen_ls)
            PREBIAS <= 1;
            w(40);
            watch(20);
            `CHK("prebias ls", 1'b1, seen_ls)
            PREBIAS <= 0;
            skip <= 0;
            w(40);
            watch(16);
            `CHK("resume hs", 1'b1, seen_hs)
        end
    endtask
    task t_pg;
        begin
            {VSNS_PG_ASSERT, VSNS_PG_RELEASE} <= 2'b11;
            w(5);
            `CHK("pg window", 1'b1, pg_pin)
            VSNS_PG_ASSERT <= 0;
            w(5);
            `CHK("pg hyst", 1'b1, pg_pin)
            VSNS_PG_RELEASE <= 0;
            w(5);
            `CHK("pg below", 1'b0, pg_pin)
            VSNS_PG_RELEASE <= 1;
            w(5);
            `CHK("pg early", 1'b0, pg_pin)
            VSNS_PG_ASSERT <= 1;
            ENABLE <= 0;
            w(5);
            `CHK("pg enable", 1'b0, pg_pin)
            ENABLE <= 1;
            w(5);
            `CHK("pg back", 1'b1, pg_pin)
        end
    endtask
    task t_ov;
        begin
            ENABLE <= 0;
            VSNS_OV <= 1;
            wait_trip(i);
            `CHK("trip delay", 1'b1, i > OVD && i < OVD + 6)
            VSNS_OV <= 0;
            ENABLE <= 1;
            w(6);
            watch(40);
            `CHK("latched hs", 1'b0, seen_hs)
            do_reset;
            skip <= 1;
            w(40);
            VSNS_OV <= 1;
            wait_trip(i);
            w(1);
            `CHK("trip hs", 1'b0, HIGH_SIDE_DRIVE)
            `CHK("trip ls", 1'b1, LOW_SIDE_DRIVE)
            `CHK("trip pg", 1'b0, pg_pin)
            VSNS_OV <= 0;
            skip <= 0;
            w(6);
            watch(40);
            `CHK("after hs", 1'b0, seen_hs)
            `CHK("after ls", 1'b0, seen_ls)
            do_reset;
            w(40);
            watch(16);
            `CHK("cycled hs", 1'b1, seen_hs)
        end
    endtask
    task report_and_stop;
        begin
            if (failures == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        do_reset;
        t_bus;
        ENABLE <= 1;
        t_ff;
        t_gate;
        t_brake;
        t_pg;
        t_ov;
        report_and_stop;
    end
    initial
    begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule // testbench
